// ==== hw/card_info_params.svh ====
// bit positions, reset values, field values and timing counts of the card register bank
`ifndef CARD_INFO_PARAMS_SVH
`define CARD_INFO_PARAMS_SVH

// clock and power-up timing
`define CLK_PERIOD_NS        40
`define POWERUP_TIME_US      1000
`define POWERUP_CYCLES       ((`POWERUP_TIME_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// register selectors on the read port
`define SEL_IDENTITY         3'h0
`define SEL_CONDITIONS       3'h1
`define SEL_SPECIFIC         3'h2
`define SEL_FEATURES         3'h3
`define SEL_ADDRESS          3'h4

// reset values
`define RCA_RESET            16'h0000
`define CRC_RESET            7'h00

// identity register field positions
`define CID_MAKER_MSB        127
`define CID_MAKER_LSB        120
`define CID_OEM_MSB          119
`define CID_OEM_LSB          104
`define CID_NAME_MSB         103
`define CID_NAME_LSB         64
`define CID_REV_MSB          63
`define CID_REV_LSB          56
`define CID_SERIAL_MSB       55
`define CID_SERIAL_LSB       24
`define CID_RSV_MSB          23
`define CID_RSV_LSB          20
`define CID_DATE_MSB         19
`define CID_DATE_LSB         8
`define CRC_MSB              7
`define CRC_LSB              1
`define END_BIT              0

// operating-conditions register
`define OCR_BUSY_BIT         31
`define OCR_CCS_BIT          30
`define OCR_VDD_MSB          23
`define OCR_VDD_LSB          15
`define OCR_VDD_ONES         9'h1FF

// card-specific-data field positions
`define CSD_STRUCT_MSB       127
`define CSD_STRUCT_LSB       126
`define CSD_READ_ACCESS_TIME_MSB         119
`define CSD_READ_ACCESS_TIME_LSB         112
`define CSD_READ_ACCESS_CLOCKS_MSB         111
`define CSD_READ_ACCESS_CLOCKS_LSB         104
`define CSD_SPEED_MSB        103
`define CSD_SPEED_LSB        96
`define CSD_CCC_MSB          95
`define CSD_CCC_LSB          84
`define CSD_RBL_MSB          83
`define CSD_RBL_LSB          80
`define CSD_RPART_BIT        79
`define CSD_SIZE12_MSB       73
`define CSD_SIZE12_LSB       62
`define CSD_CURR_MSB         61
`define CSD_CURR_LSB         50
`define CSD_MULT_MSB         49
`define CSD_MULT_LSB         47
`define CSD_SIZE22_MSB       69
`define CSD_SIZE22_LSB       48
`define CSD_ERASE_BIT        46
`define CSD_SECTOR_MSB       45
`define CSD_SECTOR_LSB       39
`define CSD_WPSIZE_MSB       38
`define CSD_WPSIZE_LSB       32
`define CSD_WPEN_BIT         31
`define CSD_R2W_MSB          28
`define CSD_R2W_LSB          26
`define CSD_WBL_MSB          25
`define CSD_WBL_LSB          22
`define CSD_WPART_BIT        21
`define CSD_FMTGRP_BIT       15
`define CSD_COPY_BIT         14
`define CSD_PERM_BIT         13
`define CSD_TMP_BIT          12
`define CSD_FMT_MSB          11
`define CSD_FMT_LSB          10
`define CSD_RSV98_MSB        9
`define CSD_RSV98_LSB        8
`define CSD_FIXED_LSB        16

// card-specific-data field values, small and large capacity
`define CSD_STRUCT_SMALL     2'h0
`define CSD_STRUCT_LARGE     2'h1
`define CSD_READ_ACCESS_TIME_SMALL       8'h5E
`define CSD_READ_ACCESS_TIME_LARGE       8'h0E
`define CSD_READ_ACCESS_CLOCKS_VAL         8'h00
`define CSD_SPEED_VAL        8'h32
`define CSD_CCC_VAL          12'h5B5
`define CSD_BL_SMALL         4'hA
`define CSD_BL_LARGE         4'h9
`define CSD_CURR_VAL         12'hB6D
`define CSD_SECTOR_VAL       7'h7F
`define CSD_WPSIZE_SMALL     7'h3F
`define CSD_WPSIZE_LARGE     7'h00
`define CSD_R2W_SMALL        3'h5
`define CSD_R2W_LARGE        3'h2

// special-features register
`define SCR_SPEC_MSB         59
`define SCR_SPEC_LSB         56
`define SCR_SEC_MSB          54
`define SCR_SEC_LSB          52
`define SCR_WIDTH_MSB        51
`define SCR_WIDTH_LSB        48
`define SCR_SPEC_VAL         4'h2
`define SCR_SEC_SMALL        3'h2
`define SCR_SEC_LARGE        3'h3
`define SCR_WIDTH_VAL        4'h5

// crc-7 generator polynomial, low terms
`define CRC7_POLY            7'h09

`endif

// ==== hw/card_info_pkg.sv ====
// types shared by the card register bank modules
package card_info_pkg;

  typedef enum logic [1:0] {
    PWR_BUSY  = 2'b01,
    PWR_READY = 2'b10
  } pwr_state_t;

  typedef struct packed {
    pwr_state_t  state;
    logic [15:0] count;
  } timer_state_t;

  typedef struct packed {
    logic         cap_latched;
    logic         cap_high;
    logic [127:0] rd_data;
    logic         rd_valid;
    logic [15:0]  relative_card_address;
    logic         fmt_grp;
    logic         copy;
    logic         perm;
    logic         tmp;
    logic [1:0]   fmt;
    logic [1:0]   rsv98;
    logic [6:0]   crc;
    logic         crc_written;
    logic [3:0]   once_used;
    logic         prog_done;
    logic         prog_err;
  } bank_state_t;

endpackage

// ==== hw/crc7_unit.sv ====
// crc-7 over a parameterised run of bits, most significant first
`timescale 1ns/100ps
`include "card_info_params.svh"
module crc7_unit #(
  parameter int DATA_W = 120
) (
  // data in
  input  wire logic [DATA_W-1:0] data_i,
  // checksum out
  output logic      [6:0]        crc_o
);

  // serial division unrolled by the loop
  always_comb begin
    logic [6:0] acc;
    logic       fb;
    acc = 7'h00;
    fb  = 1'b0;
    for (int i = DATA_W - 1; i >= 0; i--) begin
      fb  = data_i[i] ^ acc[6];
      acc = {acc[5:0], 1'b0};
      if (fb) begin
        acc = acc ^ `CRC7_POLY;
      end
    end
    crc_o = acc;
  end

endmodule

// ==== hw/power_up_timer.sv ====
// power-up routine timer: busy until the count runs out, then ready
`timescale 1ns/100ps
module power_up_timer #(
  parameter int CYCLES = 25000
) (
  // clock and reset
  input  wire logic CORE_CLK_I,
  input  wire logic RSTN_I,
  // status
  output logic      ready_o
);

  card_info_pkg::timer_state_t cur;
  card_info_pkg::timer_state_t next_cur;

  // count up through the routine, then hold ready
  always_comb begin
    next_cur = cur;
    case (cur.state)
      card_info_pkg::PWR_BUSY: begin
        if (cur.count >= 16'(CYCLES - 1)) begin
          next_cur.state = card_info_pkg::PWR_READY;
        end else begin
          next_cur.count = cur.count + 16'h0001;
        end
      end
      card_info_pkg::PWR_READY: begin
        next_cur.state = card_info_pkg::PWR_READY;
      end
      default: begin
        next_cur.state = card_info_pkg::PWR_BUSY;
        next_cur.count = 16'h0000;
      end
    endcase
  end

  // state register
  always_ff @(posedge CORE_CLK_I) begin
    if (!RSTN_I) begin
      cur.state <= card_info_pkg::PWR_BUSY;
      cur.count <= 16'h0000;
    end else begin
      cur <= next_cur;
    end
  end

  assign ready_o = (cur.state == card_info_pkg::PWR_READY);

endmodule

// ==== hw/card_info_register_bank.sv ====
// card-side register bank: identity, conditions, specific data, features, address
// How it works
// - five readable registers: identity, conditions, specific data, features, address
// - relative address compared against command address in bus mode
// - identity register packs maker, oem, name, revision, serial, date, checksum, one
// - conditions bits 23:15 read one, all lower bits zero
// - conditions bit 31 reads zero until power-up routine ends
// - capacity flag only meaningful once ready; masked to zero while busy
// - program command changes only writable specific-data fields
// - structure code and size field placement follow capacity
// - read block length 1010 small, 1001 large
// - partial read flag one small, zero large
// - read access time 5E small, 0E large
// - clock read access time always zero
// - single block erase one, sector size all ones
// - protect group size 3F small, zero large
// - protect group enable reads zero
// - write block length equals read block length
// - partial write flag reads zero
// - four supply current fields read 101 on small cards
// - specific-data checksum at 7:1 host writable, bit 0 one
// - format group, copy, permanent, format change once; temporary any time
// - relative address resets to zero, card may assign new value later
`timescale 1ns/100ps
`include "card_info_params.svh"
module card_info_register_bank #(
  parameter int          POWERUP_CYCLES = `POWERUP_CYCLES,
  parameter logic [7:0]  MAKER_CODE     = 8'hA1,          // arbitrary value
  parameter logic [15:0] OEM_CODE       = 16'hB2C3,       // arbitrary value
  parameter logic [39:0] PRODUCT_NAME   = 40'h5445535431, // arbitrary value
  parameter logic [7:0]  PRODUCT_REV    = 8'h10,          // arbitrary value
  parameter logic [31:0] SERIAL_NUMBER  = 32'h00000001,
  parameter logic [11:0] MANUFACT_DATE  = 12'h011,
  parameter logic [11:0] SIZE_SMALL     = 12'hF00,
  parameter logic [2:0]  MULT_SMALL     = 3'h7,
  parameter logic [21:0] SIZE_LARGE     = 22'h001DFF
) (
  // clock and reset
  input  wire logic         CORE_CLK_I,
  input  wire logic         RSTN_I,
  // capacity strap, caught after reset release
  input  wire logic         HIGH_CAPACITY_I,
  // bus mode and command address
  input  wire logic         SD_MODE_I,
  input  wire logic [15:0]  CMD_RCA_I,
  // register read request
  input  wire logic         RD_REQ_I,
  input  wire logic [2:0]   RD_SEL_I,
  // specific-data program request
  input  wire logic         PROG_REQ_I,
  input  wire logic [127:0] PROG_DATA_I,
  // address assignment request
  input  wire logic         RCA_SET_I,
  input  wire logic [15:0]  RCA_NEW_I,
  // read answer
  output logic              RD_VALID_O,
  output logic      [127:0] RD_DATA_O,
  // program answer
  output logic              PROG_DONE_O,
  output logic              PROG_ERR_O,
  // status
  output logic              CARD_READY_O,
  output logic      [15:0]  RCA_O,
  output logic              ADDR_MATCH_O
);

  card_info_pkg::bank_state_t cur;
  card_info_pkg::bank_state_t next_cur;

  logic         ready;
  logic         cap;
  logic [127:0] card_identity;
  logic [127:0] card_specific_data;
  logic [127:0] csd_body;
  logic [127:0] cid_body;
  logic [31:0]  operating_conditions;
  logic [63:0]  special_features;
  logic [6:0]   cid_crc;
  logic [6:0]   csd_crc;
  logic [127:0] prog_cur;
  logic         fixed_differ;
  logic [3:0]   once_new;
  logic [3:0]   once_change;
  logic         once_violate;

  // power-up routine
  power_up_timer #(
    .CYCLES     (POWERUP_CYCLES)
  ) u_timer (
    .CORE_CLK_I (CORE_CLK_I),
    .RSTN_I     (RSTN_I),
    .ready_o    (ready)
  );

  assign cap = cur.cap_high;

  // identity register fields
  always_comb begin
    cid_body = 128'h0;
    cid_body[`CID_MAKER_MSB:`CID_MAKER_LSB]   = MAKER_CODE;
    cid_body[`CID_OEM_MSB:`CID_OEM_LSB]       = OEM_CODE;
    cid_body[`CID_NAME_MSB:`CID_NAME_LSB]     = PRODUCT_NAME;
    cid_body[`CID_REV_MSB:`CID_REV_LSB]       = PRODUCT_REV;
    cid_body[`CID_SERIAL_MSB:`CID_SERIAL_LSB] = SERIAL_NUMBER;
    cid_body[`CID_RSV_MSB:`CID_RSV_LSB]       = 4'h0;
    cid_body[`CID_DATE_MSB:`CID_DATE_LSB]     = MANUFACT_DATE;
  end

  // identity checksum over bits 127:8
  crc7_unit #(
    .DATA_W (120)
  ) u_cid_crc (
    .data_i (cid_body[127:8]),
    .crc_o  (cid_crc)
  );

  // identity with checksum and end bit
  always_comb begin
    card_identity = cid_body;
    card_identity[`CRC_MSB:`CRC_LSB] = cid_crc;
    card_identity[`END_BIT]          = 1'b1;
  end

  // operating conditions
  always_comb begin
    operating_conditions = 32'h0;
    operating_conditions[`OCR_VDD_MSB:`OCR_VDD_LSB] = `OCR_VDD_ONES;
    operating_conditions[`OCR_BUSY_BIT]             = ready;
    operating_conditions[`OCR_CCS_BIT]              = ready & cap;
  end

  // specific-data body, layout chosen by capacity
  always_comb begin
    csd_body = 128'h0;
    csd_body[`CSD_READ_ACCESS_CLOCKS_MSB:`CSD_READ_ACCESS_CLOCKS_LSB]   = `CSD_READ_ACCESS_CLOCKS_VAL;
    csd_body[`CSD_SPEED_MSB:`CSD_SPEED_LSB] = `CSD_SPEED_VAL;
    csd_body[`CSD_CCC_MSB:`CSD_CCC_LSB]     = `CSD_CCC_VAL;
    csd_body[`CSD_ERASE_BIT]                = 1'b1;
    csd_body[`CSD_SECTOR_MSB:`CSD_SECTOR_LSB] = `CSD_SECTOR_VAL;
    csd_body[`CSD_WPEN_BIT]                 = 1'b0;
    csd_body[`CSD_WPART_BIT]                = 1'b0;
    if (cap) begin
      csd_body[`CSD_STRUCT_MSB:`CSD_STRUCT_LSB] = `CSD_STRUCT_LARGE;
      csd_body[`CSD_READ_ACCESS_TIME_MSB:`CSD_READ_ACCESS_TIME_LSB]     = `CSD_READ_ACCESS_TIME_LARGE;
      csd_body[`CSD_RBL_MSB:`CSD_RBL_LSB]       = `CSD_BL_LARGE;
      csd_body[`CSD_RPART_BIT]                  = 1'b0;
      csd_body[`CSD_SIZE22_MSB:`CSD_SIZE22_LSB] = SIZE_LARGE;
      csd_body[`CSD_WPSIZE_MSB:`CSD_WPSIZE_LSB] = `CSD_WPSIZE_LARGE;
      csd_body[`CSD_R2W_MSB:`CSD_R2W_LSB]       = `CSD_R2W_LARGE;
      csd_body[`CSD_WBL_MSB:`CSD_WBL_LSB]       = `CSD_BL_LARGE;
    end else begin
      csd_body[`CSD_STRUCT_MSB:`CSD_STRUCT_LSB] = `CSD_STRUCT_SMALL;
      csd_body[`CSD_READ_ACCESS_TIME_MSB:`CSD_READ_ACCESS_TIME_LSB]     = `CSD_READ_ACCESS_TIME_SMALL;
      csd_body[`CSD_RBL_MSB:`CSD_RBL_LSB]       = `CSD_BL_SMALL;
      csd_body[`CSD_RPART_BIT]                  = 1'b1;
      csd_body[`CSD_SIZE12_MSB:`CSD_SIZE12_LSB] = SIZE_SMALL;
      csd_body[`CSD_CURR_MSB:`CSD_CURR_LSB]     = `CSD_CURR_VAL;
      csd_body[`CSD_MULT_MSB:`CSD_MULT_LSB]     = MULT_SMALL;
      csd_body[`CSD_WPSIZE_MSB:`CSD_WPSIZE_LSB] = `CSD_WPSIZE_SMALL;
      csd_body[`CSD_R2W_MSB:`CSD_R2W_LSB]       = `CSD_R2W_SMALL;
      csd_body[`CSD_WBL_MSB:`CSD_WBL_LSB]       = `CSD_BL_SMALL;
    end
    // programmable bits
    csd_body[`CSD_FMTGRP_BIT]             = cur.fmt_grp;
    csd_body[`CSD_COPY_BIT]               = cur.copy;
    csd_body[`CSD_PERM_BIT]               = cur.perm;
    csd_body[`CSD_TMP_BIT]                = cur.tmp;
    csd_body[`CSD_FMT_MSB:`CSD_FMT_LSB]   = cur.fmt;
    csd_body[`CSD_RSV98_MSB:`CSD_RSV98_LSB] = cur.rsv98;
  end

  // specific-data checksum over bits 127:8
  crc7_unit #(
    .DATA_W (120)
  ) u_csd_crc (
    .data_i (csd_body[127:8]),
    .crc_o  (csd_crc)
  );

  // host checksum once written, computed checksum before that
  always_comb begin
    card_specific_data = csd_body;
    card_specific_data[`CRC_MSB:`CRC_LSB] = cur.crc_written ? cur.crc : csd_crc;
    card_specific_data[`END_BIT]          = 1'b1;
  end

  // special features
  always_comb begin
    special_features = 64'h0;
    special_features[`SCR_SPEC_MSB:`SCR_SPEC_LSB]   = `SCR_SPEC_VAL;
    special_features[`SCR_SEC_MSB:`SCR_SEC_LSB]     = cap ? `SCR_SEC_LARGE : `SCR_SEC_SMALL;
    special_features[`SCR_WIDTH_MSB:`SCR_WIDTH_LSB] = `SCR_WIDTH_VAL;
  end

  // program checks: fixed fields must match, once bits change at most once
  always_comb begin
    prog_cur     = card_specific_data;
    fixed_differ = (PROG_DATA_I[127:`CSD_FIXED_LSB] != prog_cur[127:`CSD_FIXED_LSB]);
    once_new     = {PROG_DATA_I[`CSD_FMTGRP_BIT], PROG_DATA_I[`CSD_COPY_BIT],
                    PROG_DATA_I[`CSD_PERM_BIT],
                    |(PROG_DATA_I[`CSD_FMT_MSB:`CSD_FMT_LSB] ^ cur.fmt)};
    once_change  = {once_new[3] ^ cur.fmt_grp, once_new[2] ^ cur.copy,
                    once_new[1] ^ cur.perm, once_new[0]};
    once_violate = |(once_change & cur.once_used);
  end

  // next state
  always_comb begin
    next_cur           = cur;
    next_cur.rd_valid  = 1'b0;
    next_cur.prog_done = 1'b0;
    next_cur.prog_err  = 1'b0;
    // capacity strap caught on the first edge after release
    if (!cur.cap_latched) begin
      next_cur.cap_latched = 1'b1;
      next_cur.cap_high    = HIGH_CAPACITY_I;
    end
    // register read
    if (RD_REQ_I) begin
      next_cur.rd_valid = 1'b1;
      if (RD_SEL_I == `SEL_IDENTITY) begin
        next_cur.rd_data = card_identity;
      end else if (RD_SEL_I == `SEL_CONDITIONS) begin
        next_cur.rd_data = {96'h0, operating_conditions};
      end else if (RD_SEL_I == `SEL_SPECIFIC) begin
        next_cur.rd_data = card_specific_data;
      end else if (RD_SEL_I == `SEL_FEATURES) begin
        next_cur.rd_data = {64'h0, special_features};
      end else if (RD_SEL_I == `SEL_ADDRESS) begin
        next_cur.rd_data = {112'h0, cur.relative_card_address};
      end else begin
        next_cur.rd_data = 128'h0;
      end
    end
    // specific-data program
    if (PROG_REQ_I) begin
      if (fixed_differ || once_violate) begin
        next_cur.prog_err = 1'b1;
      end else begin
        next_cur.prog_done   = 1'b1;
        next_cur.fmt_grp     = PROG_DATA_I[`CSD_FMTGRP_BIT];
        next_cur.copy        = PROG_DATA_I[`CSD_COPY_BIT];
        next_cur.perm        = PROG_DATA_I[`CSD_PERM_BIT];
        next_cur.tmp         = PROG_DATA_I[`CSD_TMP_BIT];
        next_cur.fmt         = PROG_DATA_I[`CSD_FMT_MSB:`CSD_FMT_LSB];
        next_cur.rsv98       = PROG_DATA_I[`CSD_RSV98_MSB:`CSD_RSV98_LSB];
        next_cur.crc         = PROG_DATA_I[`CRC_MSB:`CRC_LSB];
        next_cur.crc_written = 1'b1;
        next_cur.once_used   = cur.once_used | once_change;
      end
    end
    // address assignment once the card is initialised
    if (RCA_SET_I && ready) begin
      next_cur.relative_card_address = RCA_NEW_I;
    end
  end

  // state register
  always_ff @(posedge CORE_CLK_I) begin
    if (!RSTN_I) begin
      cur.cap_latched <= 1'b0;
      cur.cap_high    <= 1'b0;
      cur.rd_data     <= 128'h0;
      cur.rd_valid    <= 1'b0;
      cur.relative_card_address         <= `RCA_RESET;
      cur.fmt_grp     <= 1'b0;
      cur.copy        <= 1'b0;
      cur.perm        <= 1'b0;
      cur.tmp         <= 1'b0;
      cur.fmt         <= 2'h0;
      cur.rsv98       <= 2'h0;
      cur.crc         <= `CRC_RESET;
      cur.crc_written <= 1'b0;
      cur.once_used   <= 4'h0;
      cur.prog_done   <= 1'b0;
      cur.prog_err    <= 1'b0;
    end else begin
      cur <= next_cur;
    end
  end

  // outputs
  assign RD_VALID_O   = cur.rd_valid;
  assign RD_DATA_O    = cur.rd_data;
  assign PROG_DONE_O  = cur.prog_done;
  assign PROG_ERR_O   = cur.prog_err;
  assign CARD_READY_O = ready;
  assign RCA_O        = cur.relative_card_address;
  assign ADDR_MATCH_O = SD_MODE_I & (CMD_RCA_I == cur.relative_card_address);

endmodule

// ==== verification/card_info_assertions.sv ====
// concurrent checks on the ports of the card register bank
`timescale 1ns/100ps
module card_info_assertions #(
  parameter int POWERUP_CYCLES = 10
) (
  // clock, reset, strap and mode
  input wire logic         CORE_CLK_I,
  input wire logic         RSTN_I,
  input wire logic         HIGH_CAPACITY_I,
  input wire logic         SD_MODE_I,
  input wire logic [15:0]  CMD_RCA_I,
  // requests
  input wire logic         RD_REQ_I,
  input wire logic [2:0]   RD_SEL_I,
  input wire logic         PROG_REQ_I,
  input wire logic [127:0] PROG_DATA_I,
  input wire logic         RCA_SET_I,
  input wire logic [15:0]  RCA_NEW_I,
  // answers and status
  input wire logic         RD_VALID_O,
  input wire logic [127:0] RD_DATA_O,
  input wire logic         PROG_DONE_O,
  input wire logic         PROG_ERR_O,
  input wire logic         CARD_READY_O,
  input wire logic [15:0]  RCA_O,
  input wire logic         ADDR_MATCH_O
);
  logic [15:0] cnt;

  // edges since reset release, saturating
  always_ff @(posedge CORE_CLK_I) begin
    if (!RSTN_I) begin
      cnt <= 16'h0000;
    end else if (cnt != 16'hFFFF) begin
      cnt <= cnt + 16'h0001;
    end
  end

  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RSTN_I);

  // read of one register and its answer
  sequence s_rd_cid;  RD_REQ_I && RD_SEL_I == 3'h0 ##1 RD_VALID_O; endsequence
  sequence s_rd_cond; RD_REQ_I && RD_SEL_I == 3'h1 ##1 RD_VALID_O; endsequence
  sequence s_rd_csd;  RD_REQ_I && RD_SEL_I == 3'h2 ##1 RD_VALID_O; endsequence

  a_read_answer: assert property (RD_REQ_I |=> RD_VALID_O)
    else $error("read not answered next cycle");
  a_valid_cause: assert property (RD_VALID_O |-> $past(RD_REQ_I))
    else $error("read answer without request");
  a_addr_match: assert property (ADDR_MATCH_O == (SD_MODE_I && CMD_RCA_I == RCA_O))
    else $error("address match wrong");
  a_cid_frame: assert property (s_rd_cid |-> RD_DATA_O[23:20] == 4'h0 && RD_DATA_O[0])
    else $error("identity reserved or end bit wrong");
  a_cond_window: assert property (s_rd_cond |-> RD_DATA_O[29:0] == 30'h00FF8000)
    else $error("supply window wrong");
  a_busy_flag: assert property (s_rd_cond |-> RD_DATA_O[31] == $past(CARD_READY_O)
    && (RD_DATA_O[31] || !RD_DATA_O[30])) else $error("busy or capacity flag wrong");
  a_csd_fixed: assert property (s_rd_csd |-> RD_DATA_O[111:104] == 8'h00
    && RD_DATA_O[46:39] == 8'hFF && !RD_DATA_O[31] && !RD_DATA_O[21] && RD_DATA_O[0])
    else $error("fixed specific-data field wrong");
  a_blk_match: assert property (s_rd_csd |-> RD_DATA_O[25:22] == RD_DATA_O[83:80])
    else $error("write and read block length differ");
  a_prog_answer: assert property (PROG_REQ_I |=> PROG_DONE_O != PROG_ERR_O)
    else $error("program not answered once");
  a_rca_busy: assert property (!CARD_READY_O |=> $stable(RCA_O))
    else $error("address changed while busy");
  a_rca_reset: assert property (disable iff (1'b0) !RSTN_I |=> RCA_O == 16'h0000)
    else $error("address not cleared by reset");
  a_ready_time: assert property (CARD_READY_O == (cnt >= POWERUP_CYCLES))
    else $error("ready at wrong time");
endmodule

bind card_info_register_bank card_info_assertions #(.POWERUP_CYCLES(POWERUP_CYCLES)) chk (
  .CORE_CLK_I, .RSTN_I, .HIGH_CAPACITY_I, .SD_MODE_I, .CMD_RCA_I, .RD_REQ_I, .RD_SEL_I,
  .PROG_REQ_I, .PROG_DATA_I, .RCA_SET_I, .RCA_NEW_I, .RD_VALID_O, .RD_DATA_O,
  .PROG_DONE_O, .PROG_ERR_O, .CARD_READY_O, .RCA_O, .ADDR_MATCH_O);

// ==== verification/host_model.sv ====
// host side: issues reads, program images and address assignments
`timescale 1ns/100ps
module host_model (
  // clock and answers
  input wire logic         clk_i,
  input wire logic         rd_valid_i,
  input wire logic [127:0] rd_data_i,
  input wire logic         prog_done_i,
  input wire logic         prog_err_i,
  // requests
  output logic             rd_req_o,
  output logic [2:0]       rd_sel_o,
  output logic             prog_req_o,
  output logic [127:0]     prog_data_o,
  output logic             rca_set_o,
  output logic [15:0]      rca_new_o,
  output logic             cap_seen_o
);
  // idle values
  initial begin
    {rd_req_o, rd_sel_o, prog_req_o, prog_data_o, rca_set_o, rca_new_o, cap_seen_o} = '0;
  end

  // one read; qualifiers scrambled once released
  task rd(input logic [2:0] sel, output logic vld, output logic [127:0] d);
    @(negedge clk_i);
    rd_req_o = 1'h1;
    rd_sel_o = sel;
    @(negedge clk_i);
    rd_req_o = 1'h0;
    vld = rd_valid_i;
    d = rd_data_i;
    rd_sel_o = ~sel;
    if (sel == 3'h1 && d[31]) cap_seen_o = d[30];
  endtask

  // whole new specific-data image
  task prog(input logic [127:0] v, output logic done, output logic err);
    @(negedge clk_i);
    prog_req_o = 1'h1;
    prog_data_o = v;
    @(negedge clk_i);
    prog_req_o = 1'h0;
    done = prog_done_i;
    err = prog_err_i;
    prog_data_o = ~v;
  endtask

  // new relative address
  task set_rca(input logic [15:0] v);
    @(negedge clk_i);
    rca_set_o = 1'h1;
    rca_new_o = v;
    @(negedge clk_i);
    rca_set_o = 1'h0;
    rca_new_o = ~v;
  endtask
endmodule

// ==== verification/tb.sv ====
// self-checking bench for the card register bank
`timescale 1ns/100ps
module tb;
  localparam logic [7:0]  MAKER = 8'h3C;     // arbitrary value
  localparam logic [31:0] SERIAL = 32'h0BADF00D;
  localparam logic [11:0] SZS = 12'h9C3;
  localparam logic [21:0] SZL = 22'h0ABCDE;
  localparam logic [44:0] KEY_S = {2'h0, 8'h5E, 8'h00, 4'hA, 1'h1, 1'h1, 7'h7F, 7'h3F, 1'h0,
                                   4'hA, 1'h0, 1'h1};
  localparam logic [44:0] KEY_L = {2'h1, 8'h0E, 8'h00, 4'h9, 1'h0, 1'h1, 7'h7F, 7'h00, 1'h0,
                                   4'h9, 1'h0, 1'h1};
  logic         clk = 1'h0, rstn = 1'h0, hi_cap = 1'h0, sd_mode = 1'h0;
  logic [15:0]  cmd_rca = 16'h0000, rca_new, relative_card_address;
  logic         rd_req, rca_set, prog_req, vld, dn, er, rd_valid, p_done, p_err, ready, match;
  logic [2:0]   rd_sel;
  logic [127:0] prog_data, rd_data, d, cur, p;
  logic [127:0] flip [8] = '{128'h10AA, 128'h4000, 128'h4000, 128'h400, 128'h800,
                             128'h1 << 79, 128'h1000, 128'h300};
  logic [1:0]   res [8] = '{2'h2, 2'h2, 2'h1, 2'h2, 2'h1, 2'h1, 2'h2, 2'h2};
  int           err_count = 0, cmp_count = 0;

  card_info_register_bank #(.POWERUP_CYCLES(10), .MAKER_CODE(MAKER), .SERIAL_NUMBER(SERIAL),
    .SIZE_SMALL(SZS), .SIZE_LARGE(SZL)) dut (
    .CORE_CLK_I(clk), .RSTN_I(rstn), .HIGH_CAPACITY_I(hi_cap), .SD_MODE_I(sd_mode),
    .CMD_RCA_I(cmd_rca), .RD_REQ_I(rd_req), .RD_SEL_I(rd_sel), .PROG_REQ_I(prog_req),
    .PROG_DATA_I(prog_data), .RCA_SET_I(rca_set), .RCA_NEW_I(rca_new), .RD_VALID_O(rd_valid),
    .RD_DATA_O(rd_data), .PROG_DONE_O(p_done), .PROG_ERR_O(p_err), .CARD_READY_O(ready),
    .RCA_O(relative_card_address), .ADDR_MATCH_O(match));

  host_model host (.clk_i(clk), .rd_valid_i(rd_valid), .rd_data_i(rd_data),
    .prog_done_i(p_done), .prog_err_i(p_err), .rd_req_o(rd_req), .rd_sel_o(rd_sel),
    .prog_req_o(prog_req), .prog_data_o(prog_data), .rca_set_o(rca_set),
    .rca_new_o(rca_new), .cap_seen_o());

  // 25 MHz clock
  always #20 clk = ~clk;

  // reference checksum, msb first
  function automatic logic [6:0] crc7(input logic [119:0] v);
    logic [6:0] c;
    logic       fb;
    c = 7'h00;
    for (int i = 119; i >= 0; i--) begin
      fb = v[i] ^ c[6];
      c = {c[5:0], 1'h0} ^ (fb ? 7'h09 : 7'h00);
    end
    return c;
  endfunction

  task chk(input logic [127:0] got, input logic [127:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task do_reset(input logic cap);
    hi_cap = cap;
    rstn = 1'h0;
    repeat (3) @(negedge clk);
    rstn = 1'h1;
    repeat (2) @(negedge clk);
  endtask

  task wait_ready;
    for (int i = 0; i < 50 && ready !== 1'h1; i++) @(negedge clk);
    chk(ready, 1'h1, "ready");
  endtask

  task csd_check(input logic cap);
    host.rd(3'h2, vld, d);
    chk({d[127:126], d[119:104], d[83:79], d[46:31], d[25:21], d[0]}, cap ? KEY_L : KEY_S,
        "layout");
    chk(cap ? d[69:48] : d[73:62], cap ? SZL : SZS, "size");
    if (!cap) chk(d[61:50], 12'hB6D, "currents");
    chk(d[7:1], crc7(d[127:8]), "csd crc");
  endtask

  // watchdog
  initial begin
    #400000;
    err_count++;
    $display("ERROR t=%0t watchdog expired", $time);
    print_verdict;
  end

  // main sequence
  initial begin
    do_reset(1'h0);
    chk(relative_card_address, 16'h0000, "rca reset");
    host.rd(3'h1, vld, d);
    chk({vld, d[31:0]}, {1'h1, 32'h00FF8000}, "busy cond");
    host.set_rca(16'h1234);
    chk(relative_card_address, 16'h0000, "rca busy");
    wait_ready;
    host.rd(3'h1, vld, d);
    chk(d[31:0], 32'h80FF8000, "ready cond");
    host.rd(3'h0, vld, d);
    chk({d[127:120], d[55:24]}, {MAKER, SERIAL}, "identity");
    chk(d[7:0], {crc7(d[127:8]), 1'h1}, "cid crc");
    csd_check(1'h0);
    cur = d;
    for (int i = 0; i < 8; i++) begin
      p = cur ^ flip[i];
      host.prog(p, dn, er);
      chk({dn, er}, res[i], "program answer");
      if (res[i] == 2'h2) cur = p;
    end
    host.rd(3'h2, vld, d);
    chk(d, cur, "program readback");
    host.set_rca(16'hBEEF);
    chk(relative_card_address, 16'hBEEF, "rca set");
    host.rd(3'h4, vld, d);
    chk(d, 128'hBEEF, "rca read");
    sd_mode = 1'h1;
    cmd_rca = 16'hBEEF;
    @(negedge clk);
    chk(match, 1'h1, "match");
    cmd_rca = 16'hBEEE;
    @(negedge clk);
    chk(match, 1'h0, "mismatch");
    sd_mode = 1'h0;
    cmd_rca = 16'hBEEF;
    @(negedge clk);
    chk(match, 1'h0, "spi mode");
    host.rd(3'h3, vld, d);
    chk(vld, 1'h1, "features");
    chk(d[63:48], 16'h0225, "features fields");
    host.rd(3'h7, vld, d);
    chk({vld, d}, {1'h1, 128'h0}, "bad select");
    do_reset(1'h1);
    chk({ready, relative_card_address}, 17'h00000, "second reset");
    wait_ready;
    host.rd(3'h1, vld, d);
    chk(d[31:0], 32'hC0FF8000, "large cond");
    csd_check(1'h1);
    print_verdict;
  end
endmodule
